/* i2csar_pkg.sv */
// Constants shared by the I2C status and transmit-abort report block.
`default_nettype none
package i2csar_pkg;
	// ========================================
	// Register byte addresses
	localparam logic [31:0] STATUS_ADDR    = 32'h50001370;
	localparam logic [31:0] TX_LEVEL_ADDR  = 32'h50001374;
	localparam logic [31:0] RX_LEVEL_ADDR  = 32'h50001378;
	localparam logic [31:0] HOLD_ADDR      = 32'h5000137c;
	localparam logic [31:0] ABORT_ADDR     = 32'h50001380;
	localparam logic [31:0] CTRL_ADDR      = 32'h500013a0;
	localparam logic [31:0] ABORT_CLR_ADDR = 32'h500013a4;

	// ========================================
	// Status field positions
	localparam int ST_TARGET_BUSY = 6;
	localparam int ST_CTRL_BUSY   = 5;
	localparam int ST_RX_FULL     = 4;
	localparam int ST_RX_NONEMPTY = 3;
	localparam int ST_TX_EMPTY    = 2;
	localparam int ST_TX_ROOM     = 1;
	localparam int ST_ACTIVITY    = 0;

	// ========================================
	// Abort cause field positions
	localparam int AB_READ_CMD_REPLY = 15;
	localparam int AB_TARGET_LOST    = 14;
	localparam int AB_STALE_FLUSH    = 13;
	localparam int AB_ABORT_ARBITRATION_LOST       = 12;
	localparam int AB_CTRL_DISABLED  = 11;
	localparam int AB_LONG_RD_NORS   = 10;
	localparam int AB_SHORT_NOACK    = 0;

	// ========================================
	// Control register field positions
	localparam int CT_ENABLE      = 0;
	localparam int CT_CTRL_ALLOW  = 1;
	localparam int CT_RESTART     = 2;
	localparam int CT_LONG_ADDR   = 3;

	// ========================================
	// Reset values and timing
	localparam logic [15:0] HOLD_RESET  = 16'h0001;
	localparam logic [15:0] ABORT_RESET = 16'h0000;
	localparam logic [3:0]  CTRL_RESET  = 4'h0;
	localparam logic [5:0]  LEVEL_RESET = 6'h00;
	localparam int          ENABLE_DELAY_CYCLES = 2;

	typedef enum logic [0:0] {
		BUS_IDLE   = 1'b0,
		BUS_ANSWER = 1'b1
	} i2csar_bus_t;
endpackage
`default_nettype wire

/* i2csar_top.sv */
// Status, fill level, hold time and transmit-abort report of an I2C controller.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module i2csar_top #(
	parameter int QUEUE_DEPTH = 32
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [31:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        scl_pin,
	input  wire logic        sda_pin,
	input  wire logic        tx_push,
	input  wire logic        tx_pop,
	input  wire logic        rx_push,
	input  wire logic        rx_pop,
	input  wire logic        controller_fsm_busy,
	input  wire logic        target_fsm_busy,
	input  wire logic        target_tx_active,
	input  wire logic        target_tx_bit,
	input  wire logic        target_read_request,
	input  wire logic        target_replying,
	input  wire logic        data_cmd_write,
	input  wire logic        data_cmd_read_bit,
	input  wire logic        controller_start_request,
	input  wire logic        controller_read_request,
	input  wire logic        controller_abort_arbitration_lost,
	input  wire logic        short_addr_unanswered,
	output logic             controller_enabled,
	output logic             queue_flush,
	output logic      [15:0] data_hold_cycles,
	output logic             repeated_start_allow,
	output logic             transmit_abort_event
);
	import i2csar_pkg::*;

	// ========================================
	// State
	i2csar_bus_t bus_ff, nxt_bus;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [3:0]  ctrl_ff, nxt_ctrl;
	logic [15:0] hold_ff, nxt_hold;
	logic [15:0] abort_ff, nxt_abort;
	logic [5:0]  tx_cnt_ff, nxt_tx_cnt;
	logic [5:0]  rx_cnt_ff, nxt_rx_cnt;
	logic [ENABLE_DELAY_CYCLES-1:0] en_pipe_ff, nxt_en_pipe;
	logic        flush_ff, nxt_flush;
	logic        abev_ff, nxt_abev;
	logic        wreq_ff, nxt_wreq;
	logic [2:0]  scl_sync_ff;
	logic [1:0]  sda_sync_ff;

	logic        req;
	logic        take;
	logic        scl_rise;
	logic        target_lost;
	logic        stale_flush;
	logic        en_eff;
	logic [15:0] status_word;
	logic [15:0] abort_set;

	localparam logic [5:0] DEPTH = 6'(QUEUE_DEPTH);

	assign req  = avs_read | avs_write;
	assign take = req & (bus_ff == BUS_ANSWER);
	assign en_eff = en_pipe_ff[ENABLE_DELAY_CYCLES-1];

	// ========================================
	// Pin synchronisers
	// The first stage of each chain feeds only the second stage.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_sync_ff <= 3'h7;
			sda_sync_ff <= 2'h3;
		end else begin
			scl_sync_ff <= {scl_sync_ff[1:0], scl_pin};
			sda_sync_ff <= {sda_sync_ff[0], sda_pin};
		end
	end

	assign scl_rise = scl_sync_ff[1] & ~scl_sync_ff[2];
	// Only the sending target compares its bit; a silent slave never loses.
	assign target_lost = target_tx_active & scl_rise &
		(sda_sync_ff[1] != target_tx_bit);
	assign stale_flush = target_read_request & (tx_cnt_ff != 6'h00);

	// ========================================
	// Status word
	always_comb begin
		status_word = 16'h0000;
		status_word[ST_TARGET_BUSY] = target_fsm_busy;
		status_word[ST_CTRL_BUSY]   = controller_fsm_busy;
		status_word[ST_RX_FULL]     = (rx_cnt_ff == DEPTH);
		status_word[ST_RX_NONEMPTY] = (rx_cnt_ff != 6'h00);
		status_word[ST_TX_EMPTY]    = (tx_cnt_ff == 6'h00);
		status_word[ST_TX_ROOM]     = (tx_cnt_ff != DEPTH);
		status_word[ST_ACTIVITY]    = target_fsm_busy |
			controller_fsm_busy;
	end

	// ========================================
	// Abort causes
	always_comb begin
		abort_set = 16'h0000;
		abort_set[AB_READ_CMD_REPLY] = data_cmd_write & data_cmd_read_bit &
			target_replying;
		abort_set[AB_TARGET_LOST] = target_lost;
		abort_set[AB_STALE_FLUSH] = stale_flush;
		abort_set[AB_ABORT_ARBITRATION_LOST] = controller_abort_arbitration_lost | target_lost;
		abort_set[AB_CTRL_DISABLED] = controller_start_request &
			~ctrl_ff[CT_CTRL_ALLOW];
		abort_set[AB_LONG_RD_NORS] = controller_read_request &
			ctrl_ff[CT_LONG_ADDR] & ~ctrl_ff[CT_RESTART];
		abort_set[AB_SHORT_NOACK] = short_addr_unanswered &
			~ctrl_ff[CT_LONG_ADDR];
	end

	// ========================================
	// Next state
	always_comb begin
		nxt_bus     = bus_ff;
		nxt_rdata   = rdata_ff;
		nxt_ctrl    = ctrl_ff;
		nxt_hold    = hold_ff;
		nxt_abort   = abort_ff;
		nxt_tx_cnt  = tx_cnt_ff;
		nxt_rx_cnt  = rx_cnt_ff;
		nxt_en_pipe = {en_pipe_ff[ENABLE_DELAY_CYCLES-2:0],
			ctrl_ff[CT_ENABLE]};
		nxt_flush   = ~en_eff;
		nxt_abev    = 1'b0;

		case (bus_ff)
			BUS_IDLE: begin
				if (req) begin
					nxt_bus = BUS_ANSWER;
					nxt_rdata = 32'h00000000;
					if (avs_read) begin
						case (avs_address)
							STATUS_ADDR:   nxt_rdata[15:0] = status_word;
							TX_LEVEL_ADDR: nxt_rdata[5:0] = tx_cnt_ff;
							RX_LEVEL_ADDR: nxt_rdata[5:0] = rx_cnt_ff;
							HOLD_ADDR:     nxt_rdata[15:0] = hold_ff;
							ABORT_ADDR:    nxt_rdata[15:0] = abort_ff;
							ABORT_CLR_ADDR: nxt_rdata[15:0] = abort_ff;
							CTRL_ADDR:     nxt_rdata[3:0] = ctrl_ff;
							default:       nxt_rdata = 32'h00000000;
						endcase
					end
				end
			end
			BUS_ANSWER: begin
				nxt_bus = BUS_IDLE;
				if (avs_write) begin
					case (avs_address)
						HOLD_ADDR: nxt_hold = avs_writedata[15:0];
						CTRL_ADDR: nxt_ctrl = avs_writedata[3:0];
						default:   nxt_ctrl = ctrl_ff;
					endcase
				end
				// Reading the clear register wipes only the causes that the
				// answer carries, so one raised after the snapshot is kept
				// for the next read instead of being lost.
				if (avs_read && avs_address == ABORT_CLR_ADDR) begin
					nxt_abort = abort_ff & ~rdata_ff[15:0];
				end
			end
			default: nxt_bus = BUS_IDLE;
		endcase
		// Registered so that the handshake leaves the block from a
		// flip-flop, like every other output.
		nxt_wreq = (nxt_bus == BUS_IDLE);

		// A cause raised in the clearing cycle survives the clear.
		nxt_abort = nxt_abort | abort_set;

		// The empty flag is left out: only the stale-data flush aborts.
		if (stale_flush) begin
			nxt_abev = 1'b1;
		end

		if (tx_push && !tx_pop && tx_cnt_ff != DEPTH) begin
			nxt_tx_cnt = tx_cnt_ff + 6'h01;
		end else if (tx_pop && !tx_push && tx_cnt_ff != 6'h00) begin
			nxt_tx_cnt = tx_cnt_ff - 6'h01;
		end
		if (rx_push && !rx_pop && rx_cnt_ff != DEPTH) begin
			nxt_rx_cnt = rx_cnt_ff + 6'h01;
		end else if (rx_pop && !rx_push && rx_cnt_ff != 6'h00) begin
			nxt_rx_cnt = rx_cnt_ff - 6'h01;
		end
		if (stale_flush) begin
			nxt_tx_cnt = LEVEL_RESET;
		end
		// Queues stay erased for as long as the block is disabled.
		if (!en_eff) begin
			nxt_tx_cnt = LEVEL_RESET;
			nxt_rx_cnt = LEVEL_RESET;
		end
	end

	// ========================================
	// Registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_ff     <= BUS_IDLE;
			rdata_ff   <= 32'h00000000;
			ctrl_ff    <= CTRL_RESET;
			hold_ff    <= HOLD_RESET;
			abort_ff   <= ABORT_RESET;
			tx_cnt_ff  <= LEVEL_RESET;
			rx_cnt_ff  <= LEVEL_RESET;
			en_pipe_ff <= '0;
			flush_ff   <= 1'b1;
			abev_ff    <= 1'b0;
			wreq_ff    <= 1'b1;
		end else begin
			bus_ff     <= nxt_bus;
			rdata_ff   <= nxt_rdata;
			ctrl_ff    <= nxt_ctrl;
			hold_ff    <= nxt_hold;
			abort_ff   <= nxt_abort;
			tx_cnt_ff  <= nxt_tx_cnt;
			rx_cnt_ff  <= nxt_rx_cnt;
			en_pipe_ff <= nxt_en_pipe;
			flush_ff   <= nxt_flush;
			abev_ff    <= nxt_abev;
			wreq_ff    <= nxt_wreq;
		end
	end

	assign avs_readdata         = rdata_ff;
	assign avs_waitrequest      = wreq_ff;
	assign controller_enabled   = en_eff;
	assign queue_flush          = flush_ff;
	assign data_hold_cycles     = hold_ff;
	assign repeated_start_allow = ctrl_ff[CT_RESTART];
	assign transmit_abort_event = abev_ff;

	// ========================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_TARGET_BUSY: assert property (
		avs_read && avs_address == STATUS_ADDR && bus_ff == BUS_IDLE
		|=> avs_readdata[6] == $past(target_fsm_busy))
		else $error("target busy bit does not follow the state machine");

	AST_CTRL_BUSY: assert property (
		avs_read && avs_address == STATUS_ADDR && bus_ff == BUS_IDLE
		|=> avs_readdata[5] == $past(controller_fsm_busy)
			&& avs_readdata[0] == ($past(controller_fsm_busy)
			|| $past(target_fsm_busy)))
		else $error("controller busy or activity bit wrong");

	AST_TX_FLAGS: assert property (
		avs_read && avs_address == STATUS_ADDR && bus_ff == BUS_IDLE
		|=> avs_readdata[2] == ($past(tx_cnt_ff) == 6'h00)
			&& avs_readdata[1] == ($past(tx_cnt_ff) != DEPTH))
		else $error("transmit empty or room flag wrong");

	AST_RX_FLAGS: assert property (
		avs_read && avs_address == STATUS_ADDR && bus_ff == BUS_IDLE
		|=> avs_readdata[4] == ($past(rx_cnt_ff) == DEPTH)
			&& avs_readdata[3] == ($past(rx_cnt_ff) != 6'h00))
		else $error("receive full or nonempty flag wrong");

	AST_ENABLE_DELAY: assert property (
		$rose(ctrl_ff[CT_ENABLE]) |-> !controller_enabled ##1
			!controller_enabled ##1 controller_enabled)
		else $error("enable did not act after two cycles");

	AST_DISABLE_FLUSH: assert property (
		!controller_enabled |=> tx_cnt_ff == 6'h00 && rx_cnt_ff == 6'h00)
		else $error("queues not flushed while disabled");

	AST_TARGET_LOSS: assert property (
		target_lost |=> abort_ff[AB_TARGET_LOST] && abort_ff[AB_ABORT_ARBITRATION_LOST])
		else $error("target bus loss did not set bits 14 and 12");

	AST_STALE_FLUSH: assert property (
		stale_flush |=> transmit_abort_event && abort_ff[AB_STALE_FLUSH]
			&& tx_cnt_ff == 6'h00)
		else $error("stale data read did not abort and flush");

	AST_CTRL_DISABLED: assert property (
		controller_start_request && !ctrl_ff[CT_CTRL_ALLOW]
		|=> abort_ff[AB_CTRL_DISABLED])
		else $error("start while controller mode off not reported");

	AST_SHORT_NOACK: assert property (
		short_addr_unanswered && !ctrl_ff[CT_LONG_ADDR]
		|=> abort_ff[AB_SHORT_NOACK])
		else $error("unanswered short address not reported");

	AST_ABORT_ONLY_STALE: assert property (
		transmit_abort_event |-> $past(stale_flush))
		else $error("abort event raised without a stale flush");

	AST_HOLD_WRITE: assert property (
		take && avs_write && avs_address == HOLD_ADDR
		|=> data_hold_cycles == $past(avs_writedata[15:0]))
		else $error("hold register write did not land");

	AST_READ_CMD_REPLY: assert property (
		data_cmd_write && data_cmd_read_bit && target_replying
		|=> abort_ff[AB_READ_CMD_REPLY])
		else $error("read command during target reply not reported");

	AST_BUS_ANSWER: assert property (
		req && bus_ff == BUS_IDLE |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not exactly one cycle after request");

	COV_TARGET_LOSS: cover property (target_lost);
	COV_STALE_FLUSH: cover property (stale_flush);
	COV_RX_FULL: cover property (rx_cnt_ff == DEPTH);
	COV_ENABLE: cover property ($rose(controller_enabled));
	COV_ABORT_CLEAR: cover property (take && avs_read
		&& avs_address == ABORT_CLR_ADDR && abort_ff != 16'h0000);
endmodule
`default_nettype wire

/* i2csar_bus_peer.sv */
// Remote bus party that clocks frames and may pull the data line low.
`timescale 1ns/1ps
`default_nettype none
module i2csar_bus_peer (
	input  wire logic       go,
	input  wire logic [7:0] pull_mask,
	output logic            scl_pin,
	output logic            sda_pull
);
	// ========================================
	// Frame generator
	// The clock stands high between frames, as an idle bus does.
	initial begin
		scl_pin = 1'b1;
		sda_pull = 1'b0;
		forever begin
			@(posedge go);
			sda_pull = 1'b1;
			#80;
			for (int i = 7; i >= 0; i--) begin
				scl_pin = 1'b0;
				#40;
				sda_pull = pull_mask[i];
				#120;
				scl_pin = 1'b1;
				#160;
			end
			scl_pin = 1'b0;
			#40;
			sda_pull = 1'b1;
			#120;
			scl_pin = 1'b1;
			#80;
			sda_pull = 1'b0;
		end
	end
endmodule
`default_nettype wire

/* test_i2csar_top.sv */
// Self-checking bench for the status and abort report block.
`timescale 1ns/1ps
`default_nettype none
module test_i2csar_top;
	import i2csar_pkg::*;
	// ========================================
	// Stimulus and wiring
	logic        clk = 1'b0, sys_rst = 1'b1, go = 1'b0;
	logic        avs_read = 1'b0, avs_write = 1'b0;
	logic [31:0] avs_address = '0, avs_writedata = '0, avs_readdata;
	logic [9:0]  ev = '0;
	logic [7:0]  mask = '0;
	logic        controller_fsm_busy = 1'b0, target_fsm_busy = 1'b0;
	logic        target_tx_active = 1'b0, target_tx_bit = 1'b0;
	logic        target_replying = 1'b0, data_cmd_read_bit = 1'b0;
	logic        avs_waitrequest, scl_pin, sda_pin, sda_pull;
	logic        controller_enabled, queue_flush, transmit_abort_event;
	logic [15:0] data_hold_cycles;
	logic        repeated_start_allow;
	int          mismatches = 0, checks = 0, tae_n = 0;
	// The data line is open drain with a pull-up.
	assign sda_pin = !(sda_pull | (target_tx_active & !target_tx_bit));
	i2csar_top #(.QUEUE_DEPTH(4)) uut (.clk, .sys_rst, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .scl_pin, .sda_pin, .tx_push(ev[6]),
		.tx_pop(ev[7]), .rx_push(ev[8]), .rx_pop(ev[9]),
		.controller_fsm_busy, .target_fsm_busy, .target_tx_active,
		.target_tx_bit, .target_read_request(ev[5]), .target_replying,
		.data_cmd_write(ev[4]), .data_cmd_read_bit,
		.controller_start_request(ev[1]), .controller_read_request(ev[2]),
		.controller_abort_arbitration_lost(ev[0]), .short_addr_unanswered(ev[3]),
		.controller_enabled, .queue_flush, .data_hold_cycles,
		.repeated_start_allow, .transmit_abort_event);
	i2csar_bus_peer peer (.go, .pull_mask(mask), .scl_pin, .sda_pull);
	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (transmit_abort_event === 1'b1) tae_n++;
	// ========================================
	// Shared tasks
	task automatic results;
		if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// Holds the request until the rising edge at which waitrequest is seen
	// low and takes the read data there; only the watchdog ends a hang.
	task automatic bus(input logic w, input logic [31:0] a, d,
		output logic [31:0] q);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
		chk("waitrequest", 32'(avs_waitrequest), 32'h1);
	endtask
	task automatic rd(input logic [31:0] a, e, input string n);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(n, q, e);
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic pulse(input int k);
		ev[k] <= 1'b1;
		@(posedge clk);
		ev <= '0;
		@(posedge clk);
	endtask
	// Reading the clearing address returns the causes and wipes them.
	task automatic ab(input logic [31:0] e);
		rd(ABORT_CLR_ADDR, e, "abort");
	endtask
	// ========================================
	// Scenarios
	task automatic t_reset;
		wr(STATUS_ADDR, 32'h0);
		rd(STATUS_ADDR, 32'h6, "status");
		rd(TX_LEVEL_ADDR, 32'h0, "tx level");
		rd(RX_LEVEL_ADDR, 32'h0, "rx level");
		rd(HOLD_ADDR, 32'h1, "hold");
		rd(ABORT_ADDR, 32'h0, "abort");
		rd(32'h50001390, 32'h0, "unmapped");
		wr(HOLD_ADDR, 32'hffffa5c3);
		rd(HOLD_ADDR, 32'ha5c3, "hold");
		chk("hold out", 32'(data_hold_cycles), 32'ha5c3);
	endtask
	task automatic t_act;
		for (int i = 0; i < 4; i++) begin
			target_fsm_busy <= i[0];
			controller_fsm_busy <= i[1];
			@(posedge clk);
			rd(STATUS_ADDR, {25'h0, i[0], i[1], 3'b001, 1'b1, i[0] | i[1]},
				"activity");
		end
		target_fsm_busy <= 1'b0;
		controller_fsm_busy <= 1'b0;
	endtask
	task automatic t_queue;
		wr(CTRL_ADDR, 32'h3);
		@(negedge clk);
		chk("enabled", 32'(controller_enabled), 32'h0);
		@(negedge clk);
		chk("enabled", 32'(controller_enabled), 32'h1);
		@(negedge clk);
		chk("flush", 32'(queue_flush), 32'h0);
		chk("abort event", 32'(tae_n), 32'h0);
		// Stimulus is driven from the rising edge again from here on.
		@(posedge clk);
		repeat (5) pulse(8);
		repeat (5) pulse(6);
		rd(STATUS_ADDR, 32'h18, "full");
		rd(RX_LEVEL_ADDR, 32'h4, "rx level");
		rd(TX_LEVEL_ADDR, 32'h4, "tx level");
		pulse(9);
		pulse(7);
		rd(STATUS_ADDR, 32'h0a, "one free");
		pulse(5);
		ab(32'h2000);
		rd(TX_LEVEL_ADDR, 32'h0, "tx flushed");
		chk("abort event", 32'(tae_n), 32'h1);
		wr(CTRL_ADDR, 32'h2);
		repeat (4) @(posedge clk);
		chk("flush", 32'(queue_flush), 32'h1);
		rd(RX_LEVEL_ADDR, 32'h0, "rx flushed");
	endtask
	task automatic t_aborts;
		wr(CTRL_ADDR, 32'h0);
		pulse(1);
		ab(32'h0800);
		wr(CTRL_ADDR, 32'h2);
		pulse(1);
		ab(32'h0);
		wr(CTRL_ADDR, 32'h8);
		pulse(2);
		ab(32'h0400);
		pulse(3);
		ab(32'h0);
		wr(CTRL_ADDR, 32'hc);
		rd(CTRL_ADDR, 32'hc, "control");
		chk("restart", 32'(repeated_start_allow), 32'h1);
		pulse(2);
		ab(32'h0);
		wr(CTRL_ADDR, 32'h0);
		chk("restart", 32'(repeated_start_allow), 32'h0);
		pulse(3);
		ab(32'h1);
		pulse(0);
		ab(32'h1000);
		target_replying <= 1'b1;
		data_cmd_read_bit <= 1'b1;
		pulse(4);
		ab(32'h8000);
		target_replying <= 1'b0;
		pulse(4);
		ab(32'h0);
	endtask
	// The target sends eight bits; the ninth clock carries the far side's
	// acknowledge, which the target leaves alone, so it stops comparing.
	task automatic t_link(input logic [7:0] m, input logic [31:0] e);
		target_tx_active <= 1'b1;
		target_tx_bit <= 1'b1;
		mask <= m;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (66) @(posedge clk);
		target_tx_active <= 1'b0;
		repeat (30) @(posedge clk);
		ab(e);
	endtask
	// ========================================
	// Main sequence and watchdog
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_act;
		t_queue;
		t_aborts;
		t_link(8'h00, 32'h0);
		t_link(8'h10, 32'h5000);
		results;
	end
	initial begin
		#200000;
		mismatches++;
		results;
	end
endmodule
`default_nettype wire
